//--- hdl/internal_param_adc_redundancy.sv
// Internal-parameter conversion sequencer with digital redundancy checker.
// Assumes modulator bit streams synchronous to clk and an AXI4-Lite master.
`timescale 1ns/1ns
module internal_param_adc_redundancy #(
    parameter int unsigned CYCLES_PER_TICK = internal_param_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // AXI4-Lite write
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Modulator bit streams, ADC1 in bit 0
    input  wire logic [2:0]  mod_bits,
    // Status
    output logic             conv_busy,
    output logic             conv_done
);
    import internal_param_pkg::*;

    // ------------------------------------------------------------
    // Bus slave state
    // ------------------------------------------------------------
    logic        aw_held, next_aw_held;
    logic [7:0]  aw_addr, next_aw_addr;
    logic        w_held, next_w_held;
    logic [31:0] w_data, next_w_data;
    logic [3:0]  w_strb, next_w_strb;
    logic [1:0]  next_bresp;
    logic        next_bvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    logic        next_rvalid;
    logic [1:0]  path_select, next_path_select;
    logic        force_fail, next_force_fail;
    logic        do_write;
    logic        start_req;

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    seq_state_type state, next_state;
    logic [4:0]  div_cnt, next_div_cnt;
    logic [17:0] us_cnt, next_us_cnt;
    logic [1:0]  step, next_step;
    logic [2:0]  mode, next_mode;
    logic        redun_on, next_redun_on;
    logic [1:0]  guard_sel, next_guard_sel;
    logic [15:0] results [0:3];
    logic [15:0] next_results [0:3];
    logic        next_conv_done;
    logic        tick;
    logic        win_end;
    logic        filt_clear;
    logic [15:0] prim_result [0:2];
    logic [15:0] spare_result;
    logic [15:0] spare_eff;
    logic [15:0] diff;
    logic [3:0]  nib_flags;
    logic [15:0] checked;

    assign awready  = !aw_held && !bvalid;
    assign wready   = !w_held && !bvalid;
    assign arready  = !rvalid;
    assign do_write = aw_held && w_held && !bvalid;
    assign start_req = do_write && aw_addr == ADDR_CTRL && w_strb[0]
                       && w_data[CTRL_START_BIT];

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    always_comb begin
        next_aw_held     = aw_held;
        next_aw_addr     = aw_addr;
        next_w_held      = w_held;
        next_w_data      = w_data;
        next_w_strb      = w_strb;
        next_bresp       = bresp;
        next_bvalid      = bvalid;
        next_rdata       = rdata;
        next_rresp       = rresp;
        next_rvalid      = rvalid;
        next_path_select = path_select;
        next_force_fail  = force_fail;
        if (awvalid && awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_w_held = 1'b1;
            next_w_data = wdata;
            next_w_strb = wstrb;
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_OKAY;
            if (aw_addr == ADDR_CFG) begin
                if (w_strb[0]) begin
                    next_path_select = w_data[CFG_PS_LSB +: 2];
                    next_force_fail  = w_data[CFG_FORCE_BIT];
                end
            end else if (aw_addr == ADDR_CTRL || aw_addr == ADDR_STATUS
                         || aw_addr == ADDR_SUM || aw_addr == ADDR_TEMP
                         || aw_addr == ADDR_ANALOG || aw_addr == ADDR_DIGITAL) begin
                next_bresp = RESP_OKAY;
            end else begin
                next_bresp = RESP_SLVERR;
            end
        end
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            next_rdata  = 32'h0000_0000;
            if (araddr == ADDR_CTRL) begin
                next_rdata[CTRL_MODE_LSB +: 3] = mode;
                next_rdata[CTRL_REDUN_BIT]     = redun_on;
            end else if (araddr == ADDR_CFG) begin
                next_rdata[CFG_PS_LSB +: 2]  = path_select;
                next_rdata[CFG_FORCE_BIT]    = force_fail;
            end else if (araddr == ADDR_STATUS) begin
                next_rdata[0]   = conv_busy;
                next_rdata[2:1] = step;
            end else if (araddr == ADDR_SUM) begin
                next_rdata[15:0] = results[0];
            end else if (araddr == ADDR_TEMP) begin
                next_rdata[15:0] = results[1];
            end else if (araddr == ADDR_ANALOG) begin
                next_rdata[15:0] = results[2];
            end else if (araddr == ADDR_DIGITAL) begin
                next_rdata[15:0] = results[3];
            end else begin
                next_rresp = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_held     <= 1'b0;
            aw_addr     <= 8'h00;
            w_held      <= 1'b0;
            w_data      <= 32'h0000_0000;
            w_strb      <= 4'h0;
            bresp       <= RESP_OKAY;
            bvalid      <= 1'b0;
            rdata       <= 32'h0000_0000;
            rresp       <= RESP_OKAY;
            rvalid      <= 1'b0;
            path_select <= PS_RESET;
            force_fail  <= FORCE_RESET;
        end else begin
            aw_held     <= next_aw_held;
            aw_addr     <= next_aw_addr;
            w_held      <= next_w_held;
            w_data      <= next_w_data;
            w_strb      <= next_w_strb;
            bresp       <= next_bresp;
            bvalid      <= next_bvalid;
            rdata       <= next_rdata;
            rresp       <= next_rresp;
            rvalid      <= next_rvalid;
            path_select <= next_path_select;
            force_fail  <= next_force_fail;
        end
    end

    // ------------------------------------------------------------
    // Decimation machines
    // ------------------------------------------------------------
    // Samples once per microsecond so even the slowest window fits 16 bits
    assign tick       = state != SEQ_IDLE && div_cnt == 5'(CYCLES_PER_TICK - 1);
    assign win_end    = state == SEQ_MEAS && tick
                        && us_cnt == 18'(MEAS_US[mode][step]);
    assign filt_clear = start_req && state == SEQ_IDLE || win_end;

    generate
        for (genvar g = 0; g < 3; g++) begin : g_primary
            decimation_machine u_primary (
                .clk    (clk),
                .rst_n  (rst_n),
                .clear  (filt_clear),
                .sample (tick),
                .bit_in (mod_bits[g]),
                .result (prim_result[g])
            );
        end
    endgenerate

    // The spare shares the guarded ADC's stream with its primary
    decimation_machine u_spare (
        .clk    (clk),
        .rst_n  (rst_n),
        .clear  (filt_clear),
        .sample (tick),
        .bit_in (mod_bits[guard_sel]),
        .result (spare_result)
    );

    // ------------------------------------------------------------
    // Redundancy checker
    // ------------------------------------------------------------
    // Forcing flips bit 0, so the nibble 0 flag is always set
    assign spare_eff = spare_result ^ {15'h0000, force_fail};
    assign diff      = prim_result[guard_sel] ^ spare_eff;

    generate
        for (genvar n = 0; n < 4; n++) begin : g_nibble
            assign nib_flags[n] = |diff[4*n +: 4];
        end
    endgenerate

    // Fault only on mismatch, so the flag nibble is never zero
    assign checked = (redun_on && nib_flags != 4'h0) ? {FAULT_HIGH, nib_flags}
                                                     : prim_result[0];

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state     = state;
        next_div_cnt   = div_cnt;
        next_us_cnt    = us_cnt;
        next_step      = step;
        next_mode      = mode;
        next_redun_on  = redun_on;
        next_guard_sel = guard_sel;
        next_conv_done = 1'b0;
        for (int i = 0; i < 4; i++) begin
            next_results[i] = results[i];
        end
        if (state != SEQ_IDLE) begin
            if (tick) begin
                next_div_cnt = 5'h00;
                next_us_cnt  = us_cnt + 18'h00001;
            end else begin
                next_div_cnt = div_cnt + 5'h01;
            end
        end
        case (state)
            SEQ_IDLE: begin
                // A start while busy is ignored; this branch only runs idle
                if (start_req) begin
                    next_state    = SEQ_MEAS;
                    next_div_cnt  = 5'h00;
                    next_us_cnt   = 18'h00000;
                    next_step     = 2'h0;
                    next_mode     = w_data[CTRL_MODE_LSB +: 3];
                    // Internal quantities run on ADC1, checked only under 00/01
                    next_redun_on = w_data[CTRL_REDUN_BIT]
                                    && (path_select == PS_AUTO
                                        || path_select == PS_ADC1);
                    if (path_select == PS_AUTO || path_select == PS_ADC1) begin
                        next_guard_sel = 2'h0;
                    end else if (path_select == PS_ADC2) begin
                        next_guard_sel = 2'h1;
                    end else begin
                        next_guard_sel = 2'h2;
                    end
                end
            end
            SEQ_MEAS: begin
                if (win_end) begin
                    next_results[step] = checked;
                    next_step          = step + 2'h1;
                    if (step == 2'h3) begin
                        next_state = SEQ_TAIL;
                    end
                end
            end
            SEQ_TAIL: begin
                // Same total time with or without the comparison
                if (tick && us_cnt == 18'(TOTAL_US[mode])) begin
                    next_state     = SEQ_IDLE;
                    next_conv_done = 1'b1;
                end
            end
            default: begin
                next_state = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state     <= SEQ_IDLE;
            div_cnt   <= 5'h00;
            us_cnt    <= 18'h00000;
            step      <= 2'h0;
            mode      <= 3'h0;
            redun_on  <= 1'b0;
            guard_sel <= 2'h0;
            conv_done <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                results[i] <= RESULT_RESET;
            end
        end else begin
            state     <= next_state;
            div_cnt   <= next_div_cnt;
            us_cnt    <= next_us_cnt;
            step      <= next_step;
            mode      <= next_mode;
            redun_on  <= next_redun_on;
            guard_sel <= next_guard_sel;
            conv_done <= next_conv_done;
            for (int i = 0; i < 4; i++) begin
                results[i] <= next_results[i];
            end
        end
    end

    assign conv_busy = state != SEQ_IDLE;

endmodule : internal_param_adc_redundancy

//--- inc/internal_param_pkg.sv
// Constants, offsets and types for the internal-parameter conversion block.
// Assumes a 25 MHz clock and a 32-bit AXI4-Lite register bus.
//
// Behaviour
// - Status command converts four internal quantities
// - All eight speed modes, chosen by mode bits
// - Total time 742, 1556, 134211 us examples
// - First result 58 us, skew 140 us
// - Stack sum code, sixteen bits, group A
// - Die temperature code, sixteen bits, group A
// - Analog supply group A, digital supply group B
// - Redundant variant adds comparison, same time
// - Three primary machines plus one spare machine
// - Plain status command never applies redundancy
// - Bit stream feeds both; compare at end
// - Mismatch stores fault code 0xFF0 upper bits
// - Low bits flag mismatched nibbles
// - Fault flag nibble never all zero
// - Spare guards one ADC, chosen by path
// - Force-fail bit makes redundant compares fail
// - Internal quantities checked only under 00/01
package internal_param_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ       = 25;
    localparam int unsigned TICK_US       = 1;
    localparam int unsigned TICK_CYCLES   = TICK_US * CLK_MHZ;
    localparam int unsigned NUM_MODES     = 8;
    localparam int unsigned NUM_QUANT     = 4;

    // Mode index: 27k, 14k, 7k, 3k, 2k, 1k, 422, 26 Hz
    localparam int unsigned MEAS_US [0:7][0:3] = '{
        '{58,    104,   151,   198},
        '{87,    163,   238,   314},
        '{145,   279,   413,   547},
        '{261,   512,   762,   1012},
        '{494,   977,   1460,  1943},
        '{960,   1908,  2857,  3805},
        '{1890,  3770,  5649,  7529},
        '{29818, 59624, 89431, 119238}
    };
    localparam int unsigned TOTAL_US [0:7] = '{742, 858, 1556, 2022, 2953, 4814, 8538, 134211};

    // ------------------------------------------------------------
    // Result coding
    // ------------------------------------------------------------
    localparam logic [15:0] RESULT_MAX = 16'hdfff;
    localparam logic [11:0] FAULT_HIGH = 12'hff0;
    localparam logic [1:0]  PS_AUTO    = 2'h0;
    localparam logic [1:0]  PS_ADC1    = 2'h1;
    localparam logic [1:0]  PS_ADC2    = 2'h2;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_CFG     = 8'h04;
    localparam logic [7:0] ADDR_STATUS  = 8'h08;
    localparam logic [7:0] ADDR_SUM     = 8'h0c;
    localparam logic [7:0] ADDR_TEMP    = 8'h10;
    localparam logic [7:0] ADDR_ANALOG  = 8'h14;
    localparam logic [7:0] ADDR_DIGITAL = 8'h18;

    localparam int unsigned CTRL_START_BIT = 0;
    localparam int unsigned CTRL_REDUN_BIT = 1;
    localparam int unsigned CTRL_MODE_LSB  = 2;
    localparam int unsigned CFG_PS_LSB     = 0;
    localparam int unsigned CFG_FORCE_BIT  = 2;

    localparam logic [1:0]  PS_RESET     = 2'h0;
    localparam logic        FORCE_RESET  = 1'b0;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_MEAS = 2'b01,
        SEQ_TAIL = 2'b10
    } seq_state_type;

endpackage : internal_param_pkg

//--- hdl/decimation_machine.sv
// One integrate-and-count decimation machine for a modulator bit stream.
// Assumes sample pulses at the conversion rate and a clear at window start.
`timescale 1ns/1ns
module decimation_machine (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Stream
    input  wire logic        clear,
    input  wire logic        sample,
    input  wire logic        bit_in,
    // Result
    output logic [15:0]      result
);
    import internal_param_pkg::*;

    logic [15:0] next_result;

    always_comb begin
        next_result = result;
        if (clear) begin
            next_result = RESULT_RESET;
        end else if (sample && bit_in && result != RESULT_MAX) begin
            // Saturates so a valid code never reaches the fault range
            next_result = result + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result <= RESULT_RESET;
        end else begin
            result <= next_result;
        end
    end

endmodule : decimation_machine

//--- verif/internal_param_monitor.sv
// Assertions on the conversion block's ports.
// Assumes one clock domain; bound below.
`timescale 1ns/1ns
module internal_param_monitor
    import internal_param_pkg::*;
#(
    parameter int unsigned CYCLES_PER_TICK = 1
) (
    // Clock and reset
    input wire logic        clk, rst_n,
    // Write channels
    input wire logic [7:0]  awaddr,
    input wire logic [31:0] wdata,
    input wire logic        awvalid, awready, wvalid, wready, bvalid, bready,
    input wire logic [1:0]  bresp,
    // Read channels
    input wire logic [7:0]  araddr,
    input wire logic [31:0] rdata,
    input wire logic        arvalid, arready, rvalid, rready,
    input wire logic [1:0]  rresp,
    // Status
    input wire logic        conv_busy, conv_done
);
    logic        aw_got, w_got, mapped;
    logic [7:0]  ad, rd_addr;
    logic [31:0] wd;
    logic [2:0]  last_mode, run_mode;
    int unsigned busy_cnt, exp_len;
    assign exp_len = TOTAL_US[run_mode] * CYCLES_PER_TICK;
    assign mapped  = rd_addr <= ADDR_DIGITAL && rd_addr[1:0] == 2'h0;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_got    <= 1'b0;
            w_got     <= 1'b0;
            busy_cnt  <= 0;
            last_mode <= 3'h0;
        end else begin
            if (awvalid && awready) ad <= awaddr;
            if (wvalid && wready) wd <= wdata;
            if (arvalid && arready) rd_addr <= araddr;
            aw_got <= (aw_got || (awvalid && awready)) && !(bvalid && bready);
            w_got  <= (w_got || (wvalid && wready)) && !(bvalid && bready);
            if (aw_got && w_got && !bvalid && ad == ADDR_CTRL && wd[0]) last_mode <= wd[4:2];
            if (conv_busy && busy_cnt == 0) run_mode <= last_mode;
            busy_cnt <= conv_busy ? busy_cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence both_held;
        aw_got && w_got && !bvalid;
    endsequence
    sequence read_taken;
        arvalid && arready;
    endsequence
    a_write_answer: assert property (both_held |=> bvalid)
        else $error("late write response");
    a_bresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("bresp dropped");
    a_read_answer: assert property (read_taken |=> rvalid)
        else $error("late read data");
    a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata)
        && $stable(rresp)) else $error("rdata dropped");
    a_ar_blocked: assert property (rvalid |-> !arready)
        else $error("ar taken while busy");
    a_unmapped_err: assert property (rvalid && !mapped |-> rresp == RESP_SLVERR && rdata == 0)
        else $error("unmapped read not refused");
    a_result_code: assert property (rvalid && mapped && rd_addr >= ADDR_SUM |->
        rdata[31:16] == 0 && (rdata[15:0] <= RESULT_MAX
        || (rdata[15:4] == FAULT_HIGH && rdata[3:0] != 4'h0))) else $error("bad result code");
    a_run_length: assert property (conv_done |-> busy_cnt + CYCLES_PER_TICK + 3 >= exp_len
        && busy_cnt <= exp_len + 3) else $error("conversion length wrong");
    a_done_pulse: assert property (conv_done |=> !conv_done)
        else $error("done too long");
    a_busy_ends: assert property ($fell(conv_busy) |-> conv_done || $past(conv_done))
        else $error("busy fell without done");
endmodule : internal_param_monitor

bind internal_param_adc_redundancy internal_param_monitor #(.CYCLES_PER_TICK(CYCLES_PER_TICK))
    monitor_u (.*);

//--- verif/host_model.sv
// Host model: bus master issuing conversion commands.
// Assumes one clock; tasks called by hierarchical name.
`timescale 1ns/1ns
module host_model (
    // Clock
    input wire logic        clk,
    // Write channels
    output logic [7:0]      awaddr,
    output logic [31:0]     wdata,
    output logic [3:0]      wstrb,
    output logic            awvalid, wvalid, bready,
    input wire logic        awready, wready, bvalid,
    input wire logic [1:0]  bresp,
    // Read channels
    output logic [7:0]      araddr,
    output logic            arvalid, rready,
    input wire logic        arready, rvalid,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp
);
    initial begin
        {awaddr, wdata, wstrb, awvalid, wvalid, bready, araddr, arvalid, rready} = '0;
    end
    // Judged at negedge, where ready is settled
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d,
                             output logic [1:0] r, output bit stuck);
        bit aw_t, w_t, b_t;
        b_t = 1'b0;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (int n = 0; n < 64 && !b_t; n++) begin
            @(negedge clk);
            aw_t = awvalid && awready;
            w_t  = wvalid && wready;
            b_t  = bvalid && bready;
            r    = bresp;
            @(posedge clk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            if (b_t) bready <= 1'b0;
        end
        stuck = !b_t;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r, output bit stuck);
        bit ar_t, r_t;
        r_t = 1'b0;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (int n = 0; n < 64 && !r_t; n++) begin
            @(negedge clk);
            ar_t = arvalid && arready;
            r_t  = rvalid && rready;
            d    = rdata;
            r    = rresp;
            @(posedge clk);
            if (ar_t) arvalid <= 1'b0;
            if (r_t) rready <= 1'b0;
        end
        stuck = !r_t;
    endtask : read_reg
endmodule : host_model

//--- verif/test_internal_param_adc_redundancy.sv
// Self-checking bench for the internal-parameter conversion block.
// Assumes a one-cycle tick, set by the parameter below.
`timescale 1ns/1ns
module test_internal_param_adc_redundancy;
    import internal_param_pkg::*;
    logic        clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, conv_busy, conv_done;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [2:0]  mod_bits, cur_mode;
    int          miscompares, check_count, seed, cyc, t0;
    bit          in_conv;
    bit          hist [0:8999];
    internal_param_adc_redundancy #(.CYCLES_PER_TICK(1)) dut_u (.*);
    host_model host_u (.*);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test
    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check_val
    task automatic check_near(input string name, input int exp, input int got, input int tol);
        check_count++;
        if (got > exp + tol || got + tol < exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
        end
    endtask : check_near
    task automatic give_up(input bit st);
        if (st) begin
            miscompares++;
            end_of_test();
        end
    endtask : give_up
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        bit         st;
        host_u.write_reg(a, d, r, st);
        give_up(st);
        check_val("bresp", 32'(er), 32'(r));
    endtask : bus_wr
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        bit         st;
        host_u.read_reg(a, d, r, st);
        give_up(st);
        check_val("rresp", 32'(er), 32'(r));
    endtask : bus_rd
    // Bits low near window edges absorb one-cycle skew
    function automatic bit near_edge(input int m, input int r);
        near_edge = r < 8;
        for (int k = 0; k < 4; k++)
            near_edge |= r > MEAS_US[m][k] - 8 && r < MEAS_US[m][k] + 8;
    endfunction : near_edge
    function automatic logic [15:0] exp_count(input int m, input int k);
        int lo;
        exp_count = 16'h0;
        lo = (k == 0) ? 0 : MEAS_US[m][k - 1];
        for (int r = lo; r < MEAS_US[m][k]; r++)
            exp_count += 16'(hist[r]);
    endfunction : exp_count
    always @(posedge clk) begin
        cyc           <= cyc + 1;
        mod_bits[2:1] <= 2'($random(seed));
        if (in_conv && !near_edge(cur_mode, cyc - t0)) begin
            hist[cyc - t0] = 1'($random(seed));
            mod_bits[0]    <= hist[cyc - t0];
        end else begin
            mod_bits[0] <= 1'b0;
        end
    end
    task automatic check_idle;
        logic [31:0] d;
        check_val("busy pin", 32'h0, 32'(conv_busy));
        bus_wr(ADDR_SUM, 32'hffff, RESP_OKAY);
        bus_wr(8'h40, 32'h1, RESP_SLVERR);
        bus_rd(8'h20, d, RESP_SLVERR);
        check_val("unmapped", 32'h0, d);
        for (int i = 1; i < 7; i++) begin
            bus_rd(8'(4 * i), d, RESP_OKAY);
            check_val("reset value", 32'h0, d);
        end
    endtask : check_idle
    task automatic run(input int m, input bit rd, input logic [1:0] ps, input bit ff,
                       input bit poke);
        logic [31:0] d;
        int          n;
        bit          flt;
        flt = rd && ff && ps < 2'h2;
        foreach (hist[i]) hist[i] = 1'b0;
        cur_mode = 3'(m);
        bus_wr(ADDR_CFG, {29'h0, ff, ps}, RESP_OKAY);
        bus_wr(ADDR_CTRL, {27'h0, 3'(m), rd, 1'b1}, RESP_OKAY);
        t0      = cyc - 1;
        in_conv = 1'b1;
        if (poke) bus_wr(ADDR_CTRL, {27'h0, 3'(m + 1), 2'h1}, RESP_OKAY);
        bus_rd(ADDR_CTRL, d, RESP_OKAY);
        check_val("ctrl", {27'h0, 3'(m), rd && ps < 2'h2, 1'b0}, d & 32'h1e);
        bus_rd(ADDR_STATUS, d, RESP_OKAY);
        check_val("busy", 32'h1, d & 32'h1);
        for (n = 0; n < 9000 && conv_done !== 1'b1; n++) @(negedge clk);
        in_conv = 1'b0;
        give_up(n == 9000);
        check_near("done time", TOTAL_US[m], cyc - t0, 4);
        for (int k = 0; k < 4; k++) begin
            bus_rd(ADDR_SUM + 8'(4 * k), d, RESP_OKAY);
            check_val("result", {16'h0, flt ? {FAULT_HIGH, 4'h1} : exp_count(m, k)}, d);
        end
    endtask : run
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        end_of_test();
    end
    initial begin
        logic [31:0] rr, d;
        seed        = 3;
        cyc         = 0;
        in_conv     = 1'b0;
        miscompares = 0;
        check_count = 0;
        rst_n       = 1'b0;
        mod_bits    = 3'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        check_idle();
        for (int i = 0; i < 7; i++) begin
            rr = $random(seed);
            run(i, rr[0], rr[2:1], rr[3], 1'b0);
        end
        for (int i = 0; i < 4; i++)
            run(0, 1'b1, 2'(i), 1'b1, i == 0);
        run(0, 1'b0, 2'h0, 1'b1, 1'b1);
        run(2, 1'b1, 2'h1, 1'b0, 1'b0);
        // Slowest mode: reset cuts it short
        bus_wr(ADDR_CTRL, 32'h1d, RESP_OKAY);
        bus_rd(ADDR_CTRL, d, RESP_OKAY);
        check_val("ctrl", 32'h1c, d & 32'h1c);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        check_idle();
        end_of_test();
    end
endmodule : test_internal_param_adc_redundancy
